// ==== src/qdl_loader.v ====
// Local design decisions: register access over Wishbone and the placing of the registers.
`include "qdl_defs.vh"

// Functional notes
// - the serial data bit is shifted in msb first on each serial clock rise.
// - a frame is channel address, range mode, then a twelve-bit sample.
// - address 00, 01, 10, 11 selects channel a, b, c, d.
// - range 00 is bipolar, 01 unipolar, upper bit high is reserved.
// - bipolar samples are two's complement codes.
// - unipolar samples are straight binary codes.
// - after 16 bits a strobe fall copies the frame to the first latch.
// - a first latch holds until the next strobe addressing it.
// - in latch mode a load fall copies all first latches to second.
// - a load fall within two serial clocks of a strobe moves old data.
// - with load held low the addressed channel updates on 2nd clk fall.
// - while clear is low each output shows its range's zero code.
module qdl_loader (
  // clock and reset
  input  wire                        core_clk_in,
  input  wire                        rst_n_in,
  // wishbone slave
  input  wire                        wb_cyc_in,
  input  wire                        wb_stb_in,
  input  wire                        wb_we_in,
  input  wire [`QDL_ADR_W-1:0]       wb_adr_in,
  input  wire [31:0]                 wb_dat_in,
  input  wire [3:0]                  wb_sel_in,
  output reg  [31:0]                 wb_dat_out,
  output reg                         wb_ack_out,
  // serial pins from the host
  input  wire                        serial_clk_in,
  input  wire                        serial_data_in,
  input  wire                        transfer_strobe_n_in,
  input  wire                        load_n_in,
  input  wire                        zero_outputs_n_in,
  // converter words and range modes, channel a in the low bits
  output wire [4*`QDL_SAMPLE_W-1:0]  chan_word_out,
  output wire [7:0]                  chan_range_out,
  output reg                         range_reserved_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // two-stage release of the asynchronous reset
  reg rst_meta;
  reg rst_n;

  // release is synchronous so all flops leave reset together
  // assertion stays asynchronous; only the release is timed
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // synchronised pin levels and the edges found on them
  reg [4:0] pin_meta;
  reg [4:0] pin_sync;
  reg [4:0] pin_last;
  wire      sclk_rise;
  wire      sclk_fall;
  wire      strobe_fall;
  wire      load_fall;
  wire      load_low;
  wire      clear_low;
  wire      data_bit;

  // strobes idle high; meta only feeds sync
  // reset matches idle pins so no false edge follows reset
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 5'h1c;
      pin_sync <= 5'h1c;
      pin_last <= 5'h1c;
    end else begin
      pin_meta <= {zero_outputs_n_in, load_n_in, transfer_strobe_n_in,
                   serial_data_in, serial_clk_in};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // edges come from synced copies; raw pins never reach logic
  assign sclk_rise   = pin_sync[0] & ~pin_last[0];
  assign sclk_fall   = ~pin_sync[0] & pin_last[0];
  assign data_bit    = pin_sync[1];
  assign strobe_fall = ~pin_sync[2] & pin_last[2];
  assign load_fall   = ~pin_sync[3] & pin_last[3];
  assign load_low    = ~pin_sync[3];
  assign clear_low   = ~pin_sync[4];

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // software control bits
  reg  serial_en;
  reg  sw_load;
  wire bus_req;
  wire bus_wr;

  // only lane 0 carries control bits
  assign bus_req = wb_cyc_in & wb_stb_in;
  // a write lands on the edge where the master sees ack
  assign bus_wr  = bus_req & wb_we_in & wb_ack_out & wb_sel_in[0];

  // enable gates the shifter; load bit is a self-clearing pulse
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      serial_en <= `QDL_CTRL_RESET;
      sw_load   <= 1'b0;
    end else begin
      sw_load <= 1'b0;
      // a write of zero to the load bit does nothing
      if (bus_wr && wb_adr_in == `QDL_OFF_CTRL) begin
        serial_en <= wb_dat_in[`QDL_CTRL_EN_BIT];
        sw_load   <= wb_dat_in[`QDL_CTRL_LOAD_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // shift register and bit count
  // ----------------------------------------------------------------
  // shifter state
  reg  [`QDL_FRAME_W-1:0]     shreg;
  reg  [`QDL_FRAME_CNT_W-1:0] bit_cnt;
  wire                        frame_full;
  wire                        capture;

  assign frame_full = (bit_cnt == `QDL_FRAME_BITS);
  // a short frame is dropped rather than latched half-shifted
  assign capture    = strobe_fall & frame_full;

  // count saturates so extra clocks keep the last 16 bits
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      shreg   <= {`QDL_FRAME_W{1'b0}};
      bit_cnt <= {`QDL_FRAME_CNT_W{1'b0}};
    end else begin
      // shifting ignores the strobe; late bits slide the frame on
      if (sclk_rise && serial_en)
        shreg <= {shreg[`QDL_FRAME_W-2:0], data_bit};
      if (strobe_fall)
        bit_cnt <= {`QDL_FRAME_CNT_W{1'b0}};
      else if (sclk_rise && serial_en && !frame_full)
        bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  // fields of the frame now in the shifter
  wire [1:0]                 frame_addr;
  wire [1:0]                 frame_range;
  wire [`QDL_LATCH_W-1:0]    frame_latch;

  // slices follow the shifter; only a capture makes them count
  assign frame_addr  = shreg[`QDL_ADDR_HI:`QDL_ADDR_LO];
  assign frame_range = shreg[`QDL_RANGE_HI:`QDL_RANGE_LO];
  assign frame_latch = shreg[`QDL_LATCH_W-1:0];

  // reserved range is accepted but flagged; it converts as unipolar
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n)
      range_reserved_out <= 1'b0;
    else if (capture)
      range_reserved_out <= frame_range[`QDL_RANGE_RSV_BIT];
  end

  // ----------------------------------------------------------------
  // strobe window and second-latch updates
  // ----------------------------------------------------------------
  // window state for the two-fall delay after a strobe
  reg  [1:0] win_cnt;
  reg        win_act;
  reg  [1:0] last_addr;
  reg        load_one;
  wire       load_all;

  // window counts serial clock falls after an accepted strobe
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt   <= `QDL_WIN_ZERO;
      win_act   <= 1'b0;
      last_addr <= 2'b00;
      load_one  <= 1'b0;
    end else begin
      load_one <= 1'b0;
      // a new strobe inside the window restarts it; prev stays frozen
      if (capture) begin
        win_cnt   <= `QDL_WIN_ZERO;
        win_act   <= 1'b1;
        last_addr <= frame_addr;
      end else if (win_act && sclk_fall) begin
        win_cnt <= win_cnt + 1'b1;
        // transparent load only if the pin is still low at this fall
        if (win_cnt == `QDL_WIN_ONE) begin
          win_act  <= 1'b0;
          load_one <= load_low;
        end
      end
    end
  end

  // all-channel load from the pin or from software
  assign load_all = load_fall | sw_load;

  // ----------------------------------------------------------------
  // channel latches
  // ----------------------------------------------------------------
  // latch contents of all channels, channel a lowest
  wire [4*`QDL_LATCH_W-1:0] first_bus;
  wire [4*`QDL_LATCH_W-1:0] second_bus;

  // four identical channels; only select and load terms differ
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
      wire cap_ch;
      wire load_ch;
      // strobe and load terms of this channel
      assign cap_ch  = capture & (frame_addr == ch);
      assign load_ch = load_all |
                       (load_one & (last_addr == ch));
      qdl_chan u_chan (
        .clk_in       (core_clk_in),
        .rst_n_in     (rst_n),
        .capture_in   (cap_ch),
        .frame_in     (frame_latch),
        .hold_prev_in (win_act),
        .load_in      (load_ch),
        .use_prev_in  (win_act & ~load_one),
        .clear_in     (clear_low),
        .first_out    (first_bus[ch*`QDL_LATCH_W +: `QDL_LATCH_W]),
        .second_out   (second_bus[ch*`QDL_LATCH_W +: `QDL_LATCH_W]),
        .word_out     (chan_word_out[ch*`QDL_SAMPLE_W +: `QDL_SAMPLE_W])
      );
      // range field of the second latch
      assign chan_range_out[ch*2 +: 2] =
        second_bus[ch*`QDL_LATCH_W+`QDL_SAMPLE_W +: 2];
    end
  endgenerate

  // ----------------------------------------------------------------
  // wishbone read and ack
  // ----------------------------------------------------------------
  // read mux state
  reg [31:0] next_rdata;
  reg [1:0]  rd_ch;

  // unmapped offsets read zero and still ack
  always @* begin
    next_rdata = 32'h0000_0000;
    rd_ch      = wb_adr_in[3:2];
    case (wb_adr_in)
      `QDL_OFF_CTRL: begin
        next_rdata[`QDL_CTRL_EN_BIT] = serial_en;
      end
      `QDL_OFF_STATUS: begin
        // bit count, window and reserved flags, and live load and clear pin levels
        next_rdata[`QDL_FRAME_CNT_W-1:0] = bit_cnt;
        next_rdata[`QDL_ST_WIN_BIT]      = win_act;
        next_rdata[`QDL_ST_LOAD_BIT]     = load_low;
        next_rdata[`QDL_ST_CLR_BIT]      = clear_low;
        next_rdata[`QDL_ST_RSV_BIT]      = range_reserved_out;
      end
      `QDL_OFF_CH_A, `QDL_OFF_CH_B, `QDL_OFF_CH_C, `QDL_OFF_CH_D: begin
        // second latch low half, first latch high half
        next_rdata[`QDL_LATCH_W-1:0] =
          second_bus[rd_ch*`QDL_LATCH_W +: `QDL_LATCH_W];
        next_rdata[16 +: `QDL_LATCH_W] =
          first_bus[rd_ch*`QDL_LATCH_W +: `QDL_LATCH_W];
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // one wait state; ack drops the cycle after it was given
  // a master holding stb past ack gets a fresh ack every other cycle
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req & ~wb_ack_out;
      if (bus_req && !wb_ack_out)
        wb_dat_out <= next_rdata;
    end
  end

endmodule

// ==== src/qdl_defs.vh ====
`ifndef QDL_DEFS_VH
`define QDL_DEFS_VH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define QDL_FRAME_W       16
`define QDL_FRAME_CNT_W   5
`define QDL_FRAME_BITS    5'd16
`define QDL_ADDR_HI       15
`define QDL_ADDR_LO       14
`define QDL_RANGE_HI      13
`define QDL_RANGE_LO      12
`define QDL_SAMPLE_HI     11
`define QDL_SAMPLE_W      12
`define QDL_LATCH_W       14

// ----------------------------------------------------------------
// range modes and zero codes
// ----------------------------------------------------------------
`define QDL_RANGE_BIP     2'b00
`define QDL_RANGE_UNI     2'b01
`define QDL_RANGE_RSV_BIT 1
`define QDL_SIGN_BIT      11
`define QDL_BIP_ZERO      12'h800
`define QDL_UNI_ZERO      12'h000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define QDL_WIN_FALLS     2'd2
`define QDL_WIN_ZERO      2'd0
`define QDL_WIN_ONE       2'd1

// ----------------------------------------------------------------
// wishbone register map
// ----------------------------------------------------------------
`define QDL_ADR_W         8
`define QDL_OFF_CTRL      8'h00
`define QDL_OFF_STATUS    8'h04
`define QDL_OFF_CH_A      8'h10
`define QDL_OFF_CH_B      8'h14
`define QDL_OFF_CH_C      8'h18
`define QDL_OFF_CH_D      8'h1c
`define QDL_CTRL_EN_BIT   0
`define QDL_CTRL_LOAD_BIT 1
`define QDL_CTRL_RESET    1'b1
`define QDL_ST_WIN_BIT    8
`define QDL_ST_LOAD_BIT   9
`define QDL_ST_CLR_BIT    10
`define QDL_ST_RSV_BIT    11

`endif

// ==== src/qdl_chan.v ====
`include "qdl_defs.vh"

// first latch, previous copy and second latch of one channel
module qdl_chan (
  // clock and reset
  input  wire                        clk_in,
  input  wire                        rst_n_in,
  // latch controls
  input  wire                        capture_in,
  input  wire [`QDL_LATCH_W-1:0]     frame_in,
  input  wire                        hold_prev_in,
  input  wire                        load_in,
  input  wire                        use_prev_in,
  input  wire                        clear_in,
  // latch contents and converter word
  output reg  [`QDL_LATCH_W-1:0]     first_out,
  output reg  [`QDL_LATCH_W-1:0]     second_out,
  output reg  [`QDL_SAMPLE_W-1:0]    word_out
);

  reg  [`QDL_LATCH_W-1:0]  prev;
  wire [1:0]               range;
  wire [`QDL_SAMPLE_W-1:0] sample;
  reg  [`QDL_SAMPLE_W-1:0] next_word;

  assign range  = second_out[`QDL_RANGE_HI-`QDL_RANGE_LO+
                  `QDL_SAMPLE_W:`QDL_SAMPLE_W];
  assign sample = second_out[`QDL_SAMPLE_W-1:0];

  // converter word: offset binary for bipolar, straight for unipolar
  always @* begin
    if (clear_in) begin
      if (range == `QDL_RANGE_BIP)
        next_word = `QDL_BIP_ZERO;
      else
        next_word = `QDL_UNI_ZERO;
    end else if (range == `QDL_RANGE_BIP) begin
      next_word = {~sample[`QDL_SIGN_BIT],
                   sample[`QDL_SIGN_BIT-1:0]};
    end else begin
      next_word = sample;
    end
  end

  // latch pair; prev freezes while the strobe window is open
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_out  <= {`QDL_LATCH_W{1'b0}};
      prev       <= {`QDL_LATCH_W{1'b0}};
      second_out <= {`QDL_LATCH_W{1'b0}};
      word_out   <= `QDL_BIP_ZERO;
    end else begin
      if (capture_in)
        first_out <= frame_in;
      if (!hold_prev_in)
        prev <= first_out;
      if (load_in)
        second_out <= use_prev_in ? prev : first_out;
      word_out <= next_word;
    end
  end

endmodule

// ==== dv/qdl_loader_chk.sv ====
`include "qdl_defs.vh"

module qdl_loader_chk (
  input logic        core_clk_in,
  input logic        rst_n_in,
  input logic        wb_cyc_in,
  input logic        wb_stb_in,
  input logic        wb_we_in,
  input logic [7:0]  wb_adr_in,
  input logic [31:0] wb_dat_in,
  input logic [3:0]  wb_sel_in,
  input logic [31:0] wb_dat_out,
  input logic        wb_ack_out,
  input logic        serial_clk_in,
  input logic        serial_data_in,
  input logic        transfer_strobe_n_in,
  input logic        load_n_in,
  input logic        zero_outputs_n_in,
  input logic [47:0] chan_word_out,
  input logic [7:0]  chan_range_out,
  input logic        range_reserved_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [3:0] ld_age, st_age;
  logic       zero_ok, mapped, sw_ld;
  // software load: a write of the load bit to the control word
  assign sw_ld = wb_ack_out && wb_we_in && wb_adr_in == 8'h00 &&
                 wb_sel_in[0] && wb_dat_in[1];
  // cycles since load, clear or a software load; outputs move near these
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in) ld_age <= 4'h0;
    else if (!load_n_in || !zero_outputs_n_in || sw_ld) ld_age <= 4'h0;
    else if (ld_age != 4'hf) ld_age <= ld_age + 4'h1;
  // cycles since the strobe was low
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in) st_age <= 4'h0;
    else if (!transfer_strobe_n_in) st_age <= 4'h0;
    else if (st_age != 4'hf) st_age <= st_age + 4'h1;
  // every channel at the zero code of its range
  always_comb begin
    zero_ok = 1'b1;
    for (int c = 0; c < 4; c++)
      if (chan_word_out[12*c +: 12] != ((chan_range_out[2*c +: 2] == 2'b00)
          ? 12'h800 : 12'h000)) zero_ok = 1'b0;
  end
  assign mapped = wb_adr_in inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c};
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_rd_a;
    wb_ack_out && !wb_we_in && wb_adr_in == 8'h10;
  endsequence
  AST_ACK_ONE: assert property (s_req |=> wb_ack_out)
    else $error("ack not one cycle after request");
  AST_ACK_DROP: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  AST_UNMAPPED: assert property (wb_ack_out && !wb_we_in && !mapped
    |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
  AST_CH_A_READ: assert property (
    s_rd_a ##0 ld_age == 4'hf |-> wb_dat_out[13:0] == {chan_range_out[1:0],
    chan_word_out[11:0] ^ {chan_range_out[1:0] == 2'b00, 11'h0}})
    else $error("word coding disagrees with latch");
  AST_CLEAR_ZERO: assert property (
    !zero_outputs_n_in [*6] |-> zero_ok)
    else $error("outputs not at zero code during clear");
  AST_WORD_CAUSE: assert property (
    $changed(chan_word_out) |-> ld_age < 4'd8)
    else $error("word moved without load or clear");
  AST_RANGE_CAUSE: assert property (
    $changed(chan_range_out) |-> ld_age < 4'd8)
    else $error("range moved without load");
  AST_RSV_CAUSE: assert property (
    $changed(range_reserved_out) |-> st_age < 4'd8)
    else $error("reserved flag moved without strobe");
endmodule

bind qdl_loader qdl_loader_chk u_chk (.core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
  .wb_sel_in(wb_sel_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .serial_clk_in(serial_clk_in), .serial_data_in(serial_data_in),
  .transfer_strobe_n_in(transfer_strobe_n_in), .load_n_in(load_n_in),
  .zero_outputs_n_in(zero_outputs_n_in), .chan_word_out(chan_word_out),
  .chan_range_out(chan_range_out), .range_reserved_out(range_reserved_out));

// ==== dv/qdl_host.sv ====
// host controller on the serial pins; clock stands still between frames
module qdl_host (
  input  wire logic clk_in,
  output logic      sclk_out,
  output logic      sdat_out,
  output logic      transfer_strobe_n_n_out,
  output logic      load_n_out,
  output logic      zero_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out = 1'b0;
    sdat_out = 1'b0;
    transfer_strobe_n_n_out = 1'b1;
    load_n_out = 1'b1;
    zero_n_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic pins(input logic ld, input logic zr);
    @(posedge clk_in);
    load_n_out <= ld;
    zero_n_out <= zr;
  endtask
  // half periods of 4 cycles so the sync flops never miss an edge
  task automatic pulse();
    tick(4);
    sclk_out <= 1'b1;
    tick(4);
    sclk_out <= 1'b0;
  endtask
  task automatic send(input logic [15:0] frame, input logic early);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_in);
      sdat_out <= frame[i];
      pulse();
    end
    tick(4);
    transfer_strobe_n_n_out <= 1'b0;
    sdat_out <= ~frame[0];
    if (early) begin
      tick(4);
      load_n_out <= 1'b0;
      tick(4);
      load_n_out <= 1'b1;
    end
    pulse();
    pulse();
    tick(4);
    transfer_strobe_n_n_out <= 1'b1;
  endtask
endmodule

// ==== dv/qdl_loader_test.sv ====
module qdl_loader_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'hf;
  logic [31:0] rdat, q;
  logic        ack, rsv;
  wire         sclk, sdat, transfer_strobe_n_n, load_n, zero_n;
  logic [47:0] words;
  logic [7:0]  ranges;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          ncyc = 0;

  qdl_loader u_dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel),
    .wb_dat_out(rdat), .wb_ack_out(ack), .serial_clk_in(sclk),
    .serial_data_in(sdat), .transfer_strobe_n_in(transfer_strobe_n_n),
    .load_n_in(load_n), .zero_outputs_n_in(zero_n),
    .chan_word_out(words), .chan_range_out(ranges),
    .range_reserved_out(rsv));
  qdl_host u_host (.clk_in(clk), .sclk_out(sclk), .sdat_out(sdat),
    .transfer_strobe_n_n_out(transfer_strobe_n_n), .load_n_out(load_n), .zero_n_out(zero_n));

  always #5 clk = ~clk;
  // a hang ends in the same closing report
  always @(posedge clk) begin
    ncyc++;
    if (ncyc == 6000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // classic cycle; held until ack is sampled, released at that edge
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
  endtask
  task automatic t_reset();
    chk(words, {4{12'h800}});
    wb_xfer(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h1);
    wb_xfer(1'b1, 8'h20, 32'hffff_ffff, q);
    wb_xfer(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_frames();
    u_host.send(16'h07ff, 1'b0);
    u_host.send(16'h5fff, 1'b0);
    u_host.send(16'h8800, 1'b0);
    u_host.send(16'hd000, 1'b0);
    chk(words, {4{12'h800}});
    u_host.pins(1'b0, 1'b1);
    u_host.pins(1'b1, 1'b1);
    u_host.tick(12);
    chk(words, {12'h000, 12'h000, 12'hfff, 12'hfff});
    chk(ranges, 8'h44);
    wb_xfer(1'b0, 8'h14, 32'h0, q);
    chk(q, 32'h1fff_1fff);
    wb_xfer(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h07ff_07ff);
    $display("frame test done");
  endtask
  task automatic t_modes();
    u_host.send(16'h0000, 1'b1);
    u_host.tick(12);
    chk(words[11:0], 12'hfff);
    u_host.pins(1'b0, 1'b1);
    u_host.send(16'hd123, 1'b0);
    u_host.tick(12);
    chk(words, {12'h123, 12'h000, 12'hfff, 12'h800});
    u_host.pins(1'b1, 1'b0);
    u_host.tick(12);
    chk(words, {12'h000, 12'h800, 12'h000, 12'h800});
    u_host.pins(1'b1, 1'b1);
    u_host.tick(12);
    chk(words[47:36], 12'h123);
    u_host.send(16'haabc, 1'b0);
    u_host.tick(12);
    chk(rsv, 1'b1);
    u_host.send(16'h0000, 1'b0);
    u_host.tick(12);
    chk(rsv, 1'b0);
    $display("mode test done");
  endtask
  task automatic t_ctrl();
    wb_xfer(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h2);
    sel <= 4'he;
    wb_xfer(1'b1, 8'h00, 32'h2, q);
    sel <= 4'hf;
    u_host.tick(4);
    chk(words, {12'h123, 12'h000, 12'hfff, 12'h800});
    wb_xfer(1'b1, 8'h00, 32'h3, q);
    u_host.tick(4);
    chk(words, {12'h123, 12'habc, 12'hfff, 12'h800});
    chk(ranges, 8'h64);
    wb_xfer(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h1);
    wb_xfer(1'b1, 8'h00, 32'h0, q);
    u_host.send(16'h4555, 1'b0);
    u_host.tick(12);
    wb_xfer(1'b0, 8'h14, 32'h0, q);
    chk(q, 32'h1fff_1fff);
    wb_xfer(1'b1, 8'h00, 32'h1, q);
    $display("control test done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_frames();
    t_modes();
    t_ctrl();
    close_out();
  end
endmodule
